// file: logic/ccb_core.sv
/*
  execution core for clear, decrement, skip-on-zero, absolute jump and
  literal or instructions, with the result-null flag.
  assumes program memory returns the word for progAddr in the same cycle and
  that upperAddressLatch is driven by logic on clk.
*/
// Summary of operation
// [RULE1] clear_file_op writes zero to file register 0..127 and sets null flag
// [RULE2] clear_accumulator_op loads zero into accumulator and sets null flag
// [RULE3] decrement_file_op stores f minus one by destination bit, updates null flag
// [RULE4] decrement_skip_zero_op stores f minus one by destination, flags untouched
// [RULE5] zero decrement result replaces next instruction with idle_slot, two cycles
// [RULE6] increment_skip_zero_op stores f plus one by destination, flags untouched
// [RULE7] zero increment result replaces next instruction with idle_slot, two cycles
// [RULE8] absolute_jump_op loads literal into pc low bits, latch bits 6:3 above
// [RULE9] absolute_jump_op always takes two instruction cycles, flags untouched
// [RULE10] literal_or_op ors 8-bit literal into accumulator, updates null flag
// [RULE11] null flag set when 8-bit result is zero, cleared otherwise
module ccb_core
  import ccb_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [WORD_W-1:0] progWord,
  input wire logic [LATCH_W-1:0] upperAddressLatch,
  output logic [PC_W-1:0] progAddr,
  output logic [DATA_W-1:0] accumulator,
  output logic zeroFlag,
  output logic cycleDone
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  ccb_state_t state;
  ccb_state_t next_state;
  ccb_op_t op;
  logic [WORD_W-1:0] instrWord;
  logic [DATA_W-1:0] fileData;
  logic [DATA_W-1:0] aluOut;
  logic toFile;
  logic toAcc;
  logic touchZero;
  logic skipNext;
  logic jumpTaken;
  logic execNow;
  logic [FADDR_W-1:0] fileAddr;

  assign execNow = (state == ST_EXECUTE);
  assign fileAddr = instrWord[FADDR_W-1:0];

  // ----------------------------------------------------------------
  // file register memory
  // ----------------------------------------------------------------
  // read is launched from the fetched word so data is ready at execute;
  // a write that meets reset is dropped so a mid-run reset cannot corrupt a cell
  ccb_file_mem u_file_mem (
    .clk(clk),
    .wrEn(execNow && toFile && !rst),
    .wrAddr(fileAddr),
    .wrData(aluOut),
    .rdAddr(progWord[FADDR_W-1:0]),
    .rdData(fileData)
  );

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // unknown words fall through to an idle slot
  always_comb begin
    if ((instrWord & CLEAR_FILE_MASK) == CLEAR_FILE_MATCH) op = OP_CLEAR_FILE;
    else if ((instrWord & CLEAR_ACC_MASK) == CLEAR_ACC_MATCH) op = OP_CLEAR_ACC;
    else if ((instrWord & FILE_OP_MASK) == DECREMENT_MATCH) op = OP_DECREMENT;
    else if ((instrWord & FILE_OP_MASK) == DEC_SKIP_MATCH) op = OP_DEC_SKIP;
    else if ((instrWord & FILE_OP_MASK) == INC_SKIP_MATCH) op = OP_INC_SKIP;
    else if ((instrWord & FILE_OP_MASK) == LITERAL_OR_MATCH) op = OP_LITERAL_OR;
    else if ((instrWord & JUMP_MASK) == JUMP_MATCH) op = OP_JUMP;
    else op = OP_IDLE;
  end

  // ----------------------------------------------------------------
  // datapath
  // ----------------------------------------------------------------
  always_comb begin
    aluOut = ZERO_BYTE;
    toFile = 1'b0;
    toAcc = 1'b0;
    touchZero = 1'b0;
    skipNext = 1'b0;
    jumpTaken = 1'b0;
    unique case (op)
      OP_CLEAR_FILE: begin
        aluOut = ZERO_BYTE; // [RULE1]
        toFile = 1'b1;
        touchZero = 1'b1;
      end
      OP_CLEAR_ACC: begin
        aluOut = ZERO_BYTE; // [RULE2]
        toAcc = 1'b1;
        touchZero = 1'b1;
      end
      OP_DECREMENT: begin
        aluOut = fileData - ONE_BYTE; // [RULE3]
        toFile = instrWord[DEST_BIT];
        toAcc = !instrWord[DEST_BIT];
        touchZero = 1'b1;
      end
      OP_DEC_SKIP: begin
        aluOut = fileData - ONE_BYTE; // [RULE4]
        toFile = instrWord[DEST_BIT];
        toAcc = !instrWord[DEST_BIT];
        skipNext = (aluOut == ZERO_BYTE); // [RULE5]
      end
      OP_INC_SKIP: begin
        aluOut = fileData + ONE_BYTE; // [RULE6]
        toFile = instrWord[DEST_BIT];
        toAcc = !instrWord[DEST_BIT];
        skipNext = (aluOut == ZERO_BYTE); // [RULE7]
      end
      OP_LITERAL_OR: begin
        aluOut = accumulator | instrWord[DATA_W-1:0]; // [RULE10]
        toAcc = 1'b1;
        touchZero = 1'b1;
      end
      OP_JUMP: begin
        jumpTaken = 1'b1; // [RULE9]
      end
      OP_IDLE: begin
        aluOut = ZERO_BYTE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // a skip or jump spends one extra instruction cycle on an idle slot
  always_comb begin
    unique case (state)
      ST_DECODE: next_state = ST_EXECUTE;
      ST_EXECUTE: next_state = (skipNext || jumpTaken) ? ST_FLUSH_A : ST_DECODE; // [RULE5] [RULE7] [RULE9]
      ST_FLUSH_A: next_state = ST_FLUSH_B;
      ST_FLUSH_B: next_state = ST_DECODE;
      default: next_state = ST_DECODE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) state <= ST_DECODE;
    else state <= next_state;
  end

  // the fetched word is held for execute; the idle slot is loaded at the end of ST_FLUSH_A
  always_ff @(posedge clk) begin
    if (rst) instrWord <= IDLE_SLOT_WORD;
    else if (state == ST_DECODE) instrWord <= progWord;
    else if (state == ST_FLUSH_A) instrWord <= IDLE_SLOT_WORD;
  end

  // ----------------------------------------------------------------
  // program counter
  // ----------------------------------------------------------------
  // a skip steps over the already fetched-ahead word by one more count
  always_ff @(posedge clk) begin
    if (rst) begin
      progAddr <= PC_RESET;
    end else if (state == ST_DECODE) begin
      progAddr <= progAddr + PC_STEP;
    end else if (execNow && jumpTaken) begin
      progAddr <= {upperAddressLatch[LATCH_HI:LATCH_LO], instrWord[JLIT_W-1:0]}; // [RULE8]
    end else if (execNow && skipNext) begin
      progAddr <= progAddr + PC_STEP; // [RULE5] [RULE7]
    end
  end

  // ----------------------------------------------------------------
  // accumulator and flag
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) accumulator <= ZERO_BYTE;
    else if (execNow && toAcc) accumulator <= aluOut; // [RULE2] [RULE3] [RULE10]
  end

  // skip and jump leave the flag alone, since touchZero stays low for them
  always_ff @(posedge clk) begin
    if (rst) zeroFlag <= 1'b0;
    else if (execNow && touchZero) zeroFlag <= (aluOut == ZERO_BYTE); // [RULE1] [RULE11]
  end

  // one pulse per finished instruction cycle, flush cycles included
  always_ff @(posedge clk) begin
    if (rst) cycleDone <= 1'b0;
    else cycleDone <= (state == ST_EXECUTE) || (state == ST_FLUSH_B);
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence seqExecOf(ccb_op_t o);
    execNow && op == o;
  endsequence

  sequence seqFlushPair;
    state == ST_FLUSH_A ##1 state == ST_FLUSH_B ##1 state == ST_DECODE;
  endsequence

  AST_CLEAR_FILE: assert property (seqExecOf(OP_CLEAR_FILE) |-> u_file_mem.wrEn && u_file_mem.wrData == ZERO_BYTE ##1 zeroFlag) // [RULE1]
    else $error("clear file did not write zero and set flag");

  AST_CLEAR_ACC: assert property (seqExecOf(OP_CLEAR_ACC) |=> accumulator == ZERO_BYTE && zeroFlag) // [RULE2]
    else $error("clear accumulator failed");

  AST_DECREMENT_ACC: assert property (seqExecOf(OP_DECREMENT) ##0 !instrWord[DEST_BIT]
      |=> accumulator == $past(fileData) - ONE_BYTE && zeroFlag == (accumulator == ZERO_BYTE)) // [RULE3]
    else $error("decrement to accumulator wrong");

  AST_DEC_SKIP_FLAGS: assert property (seqExecOf(OP_DEC_SKIP) |=> $stable(zeroFlag)) // [RULE4]
    else $error("decrement skip touched flag");

  AST_DEC_SKIP_FLUSH: assert property (seqExecOf(OP_DEC_SKIP) ##0 fileData == ONE_BYTE |=> seqFlushPair) // [RULE5]
    else $error("decrement skip did not insert idle slot");

  AST_INC_SKIP_FILE: assert property (seqExecOf(OP_INC_SKIP) ##0 instrWord[DEST_BIT]
      |-> u_file_mem.wrEn && u_file_mem.wrData == fileData + ONE_BYTE ##1 $stable(zeroFlag)) // [RULE6]
    else $error("increment skip write wrong");

  AST_INC_SKIP_NOSKIP: assert property (seqExecOf(OP_INC_SKIP) ##0 aluOut != ZERO_BYTE |=> state == ST_DECODE) // [RULE7]
    else $error("increment skip skipped on nonzero");

  AST_JUMP_TARGET: assert property (seqExecOf(OP_JUMP)
      |=> progAddr == {$past(upperAddressLatch[LATCH_HI:LATCH_LO]), $past(instrWord[JLIT_W-1:0])}) // [RULE8]
    else $error("jump target wrong");

  AST_JUMP_CYCLES: assert property (seqExecOf(OP_JUMP) |=> seqFlushPair and $stable(zeroFlag) [*3]) // [RULE9]
    else $error("jump not two cycles or flag changed");

  AST_LITERAL_OR: assert property (seqExecOf(OP_LITERAL_OR)
      |=> accumulator == ($past(accumulator) | $past(instrWord[DATA_W-1:0]))
          && zeroFlag == (accumulator == ZERO_BYTE)) // [RULE10] [RULE11]
    else $error("literal or result or flag wrong");

endmodule

// file: logic/ccb_file_mem.sv
/*
  file register memory: one write port, one read port with registered data.
  assumes reads and writes are issued in different cycles by the core.
*/
module ccb_file_mem
  import ccb_pkg::*;
(
  input wire logic clk,
  input wire logic wrEn,
  input wire logic [FADDR_W-1:0] wrAddr,
  input wire logic [DATA_W-1:0] wrData,
  input wire logic [FADDR_W-1:0] rdAddr,
  output logic [DATA_W-1:0] rdData
);

  logic [DATA_W-1:0] cells [FILE_DEPTH];

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  // no reset on the array so it maps onto plain ram
  always_ff @(posedge clk) begin
    if (wrEn) begin
      cells[wrAddr] <= wrData;
    end
  end

  // read data always comes out of a register
  always_ff @(posedge clk) begin
    rdData <= cells[rdAddr];
  end

endmodule

// file: logic/ccb_pkg.sv
/*
  constants for the small instruction core: opcode patterns, field positions,
  widths and the sequencer state type.
  assumes 14-bit instruction words and a 128-byte file register space.
*/
package ccb_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int WORD_W = 14;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int JLIT_W = 11;
  localparam int PC_W = 15;
  localparam int LATCH_W = 8;
  localparam int FILE_DEPTH = 128;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int DEST_BIT = 7;
  localparam int LATCH_LO = 3;
  localparam int LATCH_HI = 6;

  // ----------------------------------------------------------------
  // opcode masks and match values
  // ----------------------------------------------------------------
  localparam logic [WORD_W-1:0] CLEAR_FILE_MASK = 14'h3f80;
  localparam logic [WORD_W-1:0] CLEAR_FILE_MATCH = 14'h0080;
  localparam logic [WORD_W-1:0] CLEAR_ACC_MASK = 14'h3ffc;
  localparam logic [WORD_W-1:0] CLEAR_ACC_MATCH = 14'h0100;
  localparam logic [WORD_W-1:0] FILE_OP_MASK = 14'h3f00;
  localparam logic [WORD_W-1:0] DECREMENT_MATCH = 14'h0300;
  localparam logic [WORD_W-1:0] DEC_SKIP_MATCH = 14'h0b00;
  localparam logic [WORD_W-1:0] INC_SKIP_MATCH = 14'h0f00;
  localparam logic [WORD_W-1:0] LITERAL_OR_MATCH = 14'h3800;
  localparam logic [WORD_W-1:0] JUMP_MASK = 14'h3800;
  localparam logic [WORD_W-1:0] JUMP_MATCH = 14'h2800;

  // ----------------------------------------------------------------
  // values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic [DATA_W-1:0] ONE_BYTE = 8'h01;
  localparam logic [PC_W-1:0] PC_RESET = 15'h0000;
  localparam logic [PC_W-1:0] PC_STEP = 15'h0001;
  localparam logic [WORD_W-1:0] IDLE_SLOT_WORD = 14'h0000;

  typedef enum logic [2:0] {
    OP_IDLE, OP_CLEAR_FILE, OP_CLEAR_ACC, OP_DECREMENT, OP_DEC_SKIP, OP_INC_SKIP, OP_JUMP, OP_LITERAL_OR
  } ccb_op_t;

  // one instruction cycle is a decode step plus an execute step
  typedef enum logic [3:0] {
    ST_DECODE = 4'b0001,
    ST_EXECUTE = 4'b0010,
    ST_FLUSH_A = 4'b0100,
    ST_FLUSH_B = 4'b1000
  } ccb_state_t;

endpackage

// file: tb/ccb_prog_mem.sv
/*
  program memory model for the instruction core: one word per address.
  assumes the bench fills rom by hierarchical write while the core is in reset.
*/
module ccb_prog_mem
  import ccb_pkg::*;
(
  input wire logic [PC_W-1:0] progAddr,
  output logic [WORD_W-1:0] progWord
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [WORD_W-1:0] rom [0:(1<<PC_W)-1];
  // unwritten space reads as idle slot, so runaway code only shows in progAddr
  initial begin
    for (int i = 0; i < (1 << PC_W); i++) rom[i] = IDLE_SLOT_WORD;
  end
  // word answers in the same cycle as the address, as the core expects
  assign progWord = rom[progAddr];
endmodule

// file: tb/testbench.sv
/*
  self-checking bench for the instruction core: one task per scenario.
  assumes ccb_core takes words from ccb_prog_mem and pulses cycleDone per cycle.
*/
module testbench import ccb_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk;
  logic rst;
  logic [LATCH_W-1:0] upperAddressLatch;
  logic [WORD_W-1:0] progWord;
  logic [PC_W-1:0] progAddr;
  logic [DATA_W-1:0] accumulator;
  logic zeroFlag;
  logic cycleDone;
  int failCount = 0;
  int checksDone = 0;
  int cycleCount = 0;

  ccb_core ccb_core_i (.clk(clk), .rst(rst), .progWord(progWord), .upperAddressLatch(upperAddressLatch),
    .progAddr(progAddr), .accumulator(accumulator), .zeroFlag(zeroFlag), .cycleDone(cycleDone));
  ccb_prog_mem ccb_prog_mem_i (.progAddr(progAddr), .progWord(progWord));

  // ----------------------------------------------------------------
  // clock, timeout and helpers
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // a hang in any wait loop ends here rather than running forever
  always @(posedge clk) begin
    cycleCount <= cycleCount + 1;
    if (cycleCount == 5000) begin
      failCount++;
      stopTest();
    end
  end
  task automatic stopTest();
    if (failCount == 0 && checksDone > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checksDone++;
    if (seen !== exp) begin
      failCount++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // reset is held while the program is loaded, so the core never fetches stale words;
  // the rom is touched only once reset has been sampled, so no fetch races the load
  task automatic start(input logic [LATCH_W-1:0] latch);
    @(posedge clk);
    rst <= 1'b1;
    upperAddressLatch <= latch;
    @(posedge clk);
    for (int i = 0; i < 16; i++) ccb_prog_mem_i.rom[i] = IDLE_SLOT_WORD;
  endtask
  task automatic go();
    repeat (5) @(posedge clk);
    @(negedge clk);
    check("reset progAddr", {1'b0, progAddr}, 16'h0000);
    check("reset outputs", {accumulator, 6'h00, zeroFlag, cycleDone}, 16'h0000);
    @(posedge clk);
    rst <= 1'b0;
  endtask
  // sampled at the falling edge, where the pulse and its results have settled
  task automatic run(input int n);
    int seen;
    int guard;
    seen = 0;
    guard = 0;
    while (seen < n && guard < 400) begin
      @(negedge clk);
      guard++;
      if (cycleDone === 1'b1) seen++;
    end
    if (seen < n) check("cycleDone count", seen[15:0], n[15:0]);
  endtask
  task automatic step(input logic [DATA_W-1:0] acc, input logic z);
    run(1);
    check("accumulator", {8'h00, accumulator}, {8'h00, acc});
    check("zeroFlag", {15'h0000, zeroFlag}, {15'h0000, z});
  endtask
  task automatic load(input int a, input logic [WORD_W-1:0] w);
    ccb_prog_mem_i.rom[a] = w;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // clear of the top file address, then decrement to both destinations
  task automatic t_clear_file();
    start(8'h00);
    load(0, 14'h3855);
    load(1, 14'h00ff);
    load(2, 14'h037f);
    load(3, 14'h03ff);
    load(4, 14'h037f);
    go();
    step(8'h55, 1'b0);
    step(8'h55, 1'b1);
    step(8'hff, 1'b0);
    step(8'hff, 1'b0);
    step(8'hfe, 1'b0);
  endtask
  // or accumulates, two of the four clear encodings, a zero or result sets the flag
  task automatic t_acc_or();
    start(8'h00);
    load(0, 14'h3855);
    load(1, 14'h38a0);
    load(2, 14'h0100);
    load(3, 14'h3800);
    load(4, 14'h38ff);
    load(5, 14'h0103);
    go();
    step(8'h55, 1'b0);
    step(8'hf5, 1'b0);
    step(8'h00, 1'b1);
    step(8'h00, 1'b1);
    step(8'hff, 1'b0);
    step(8'h00, 1'b1);
  endtask
  // decrement to zero skips the next word; flag left clear despite zero result
  task automatic t_dec_skip();
    start(8'h00);
    load(0, 14'h0082);
    load(1, 14'h3801);
    load(2, 14'h0f82);
    load(3, 14'h0b02);
    load(4, 14'h3810);
    load(5, 14'h3840);
    go();
    step(8'h00, 1'b1);
    step(8'h01, 1'b0);
    step(8'h01, 1'b0);
    check("progAddr", {1'b0, progAddr}, 16'h0003);
    step(8'h00, 1'b0);
    step(8'h00, 1'b0);
    check("progAddr", {1'b0, progAddr}, 16'h0005);
    step(8'h40, 1'b0);
  endtask
  // increment wraps 0xff to zero and skips; later words prove the file value
  task automatic t_inc_skip();
    start(8'h00);
    load(0, 14'h0084);
    load(1, 14'h0384);
    load(2, 14'h0f84);
    load(3, 14'h3802);
    load(4, 14'h0f04);
    load(5, 14'h0f84);
    load(6, 14'h0304);
    go();
    step(8'h00, 1'b1);
    step(8'h00, 1'b0);
    step(8'h00, 1'b0);
    step(8'h00, 1'b0);
    check("progAddr", {1'b0, progAddr}, 16'h0004);
    step(8'h01, 1'b0);
    step(8'h01, 1'b0);
    step(8'h00, 1'b1);
  endtask
  // latch bits 7, 1 and 0 outside 6:3 are set so a wrong slice lands elsewhere;
  // the flag is clear before the jump, so a stray zero update would show
  task automatic t_jump();
    start(8'hab);
    load(0, 14'h3801);
    load(1, 14'h2fff);
    load(2, 14'h3811);
    load(15'h2fff, 14'h3880);
    go();
    step(8'h01, 1'b0);
    step(8'h01, 1'b0);
    check("progAddr", {1'b0, progAddr}, 16'h2fff);
    step(8'h01, 1'b0);
    check("progAddr", {1'b0, progAddr}, 16'h2fff);
    step(8'h81, 1'b0);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    upperAddressLatch = 8'h00;
    t_clear_file();
    t_acc_or();
    t_dec_skip();
    t_inc_skip();
    t_jump();
    stopTest();
  end
endmodule
